// ### rtl/iepr_regs.sv
// Enable and priority registers with request gating, behind an AHB-Lite slave.
`timescale 1ns/10ps

// What this block does
// - Enable bit one passes request for register four only, zero blocks; sources 16 and up never pass.
// - Priority 111 highest, 000 disables the source.
// - Unimplemented bits read zero, ignore writes.
// - Debug port enable at bit 5, register seven.
// - Serial unit one priority bits 10:8, register two.
module iepr_regs #(
  parameter int num_src = 64
) (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Peripheral requests, bit i of register 0 at index i; indices 16 and up are always blocked
  input  wire logic [num_src-1:0]  src_req,
  // Gated requests and their priority levels towards arbitration
  output logic [num_src-1:0]       cpu_req,
  output logic [num_src*3-1:0]     cpu_level,
  // Interrupt
  output logic                     irq
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [15:0]           regs [iepr_pkg::num_regs];
  logic [15:0]           irq_status;
  logic [15:0]           irq_mask;
  iepr_pkg::iepr_req_t   req_q;
  logic                  take;
  logic [15:0]           wdata16;
  logic [num_src-1:0]    req_prev;

  function automatic logic [15:0] reg_mask(input int idx);
    case (idx)
      0:       reg_mask = iepr_pkg::mask_enable_4;
      1:       reg_mask = iepr_pkg::mask_enable_5;
      2:       reg_mask = iepr_pkg::mask_enable_6;
      3:       reg_mask = iepr_pkg::mask_enable_7;
      7:       reg_mask = iepr_pkg::mask_pri_3;
      default: reg_mask = iepr_pkg::mask_pri_full;
    endcase
  endfunction

  function automatic logic [15:0] reg_reset(input int idx);
    if (idx < 4) begin
      reg_reset = iepr_pkg::rst_enable;
    end else if (idx == 7) begin
      reg_reset = iepr_pkg::rst_pri_3;
    end else begin
      reg_reset = iepr_pkg::rst_pri_full;
    end
  endfunction

  assign take    = hsel && hready && (htrans == iepr_pkg::htrans_nonseq || htrans == iepr_pkg::htrans_seq);
  assign wdata16 = hwdata[15:0];

  // ****************************************************************
  // Address phase capture
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.valid <= take;
      req_q.write <= hwrite;
      req_q.addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************************************
  // Enable and priority registers
  // ****************************************************************
  for (genvar r = 0; r < iepr_pkg::num_regs; r++) begin : g_reg
    localparam logic [7:0] reg_off = 8'(r * 4);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        regs[r] <= reg_reset(r);
      end else if (req_q.valid && req_q.write && req_q.addr == reg_off) begin
        regs[r] <= wdata16 & reg_mask(r);
      end
    end
  end

  // ****************************************************************
  // Request gating
  // ****************************************************************
  for (genvar s = 0; s < num_src; s++) begin : g_src
    localparam int rg = s / iepr_pkg::reg_width;
    localparam int bt = s % iepr_pkg::reg_width;
    localparam int pr = s / iepr_pkg::num_fields;
    localparam int pf = (s % iepr_pkg::num_fields) * iepr_pkg::field_step;
    logic [2:0] lvl;
    logic       en;
    if (pr < 4 && rg < 4) begin : g_map
      assign lvl = regs[pr + 4][pf +: iepr_pkg::field_w];
      assign en  = regs[rg][bt];
    end else begin : g_nomap
      assign lvl = iepr_pkg::pri_off;
      assign en  = 1'b0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cpu_req[s]        <= 1'b0;
        cpu_level[s*3 +: 3] <= iepr_pkg::pri_off;
      end else begin
        cpu_req[s]          <= src_req[s] && en && (lvl != iepr_pkg::pri_off);
        cpu_level[s*3 +: 3] <= lvl;
      end
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_prev <= '0;
    end else begin
      req_prev <= cpu_req;
    end
  end

  logic [15:0] rise_per_reg;
  always_comb begin
    rise_per_reg = '0;
    for (int k = 0; k < num_src; k++) begin
      if (cpu_req[k] && !req_prev[k]) begin
        rise_per_reg[k / iepr_pkg::reg_width] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
    end else if (req_q.valid && req_q.write && req_q.addr == iepr_pkg::off_irq_status) begin
      irq_status <= (irq_status & ~wdata16) | rise_per_reg;
    end else begin
      irq_status <= irq_status | rise_per_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= '0;
    end else if (req_q.valid && req_q.write && req_q.addr == iepr_pkg::off_irq_mask) begin
      irq_mask <= wdata16;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [15:0] rd_next;
  always_comb begin
    rd_next = '0;
    for (int r = 0; r < iepr_pkg::num_regs; r++) begin
      if (haddr[7:0] == 8'(r * 4)) begin
        rd_next = regs[r];
      end
    end
    if (haddr[7:0] == iepr_pkg::off_irq_status) begin
      rd_next = irq_status;
    end
    if (haddr[7:0] == iepr_pkg::off_irq_mask) begin
      rd_next = irq_mask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (take && !hwrite) begin
      hrdata <= {16'h0000, rd_next};
    end
  end

endmodule

// ### rtl/iepr_pkg.sv
// Package of register map, field layouts and reset values for the enable and priority slice.
package iepr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] off_enable_4   = 8'h00;
  localparam logic [7:0] off_enable_5   = 8'h04;
  localparam logic [7:0] off_enable_6   = 8'h08;
  localparam logic [7:0] off_enable_7   = 8'h0c;
  localparam logic [7:0] off_priority_0 = 8'h10;
  localparam logic [7:0] off_priority_1 = 8'h14;
  localparam logic [7:0] off_priority_2 = 8'h18;
  localparam logic [7:0] off_priority_3 = 8'h1c;
  localparam logic [7:0] off_irq_status = 8'h20;
  localparam logic [7:0] off_irq_mask   = 8'h24;

  localparam int num_regs   = 8;
  localparam int reg_width  = 16;
  localparam int num_fields = 4;
  localparam int field_w    = 3;
  localparam int field_step = 4;

  // ****************************************************************
  // Implemented bit masks
  // ****************************************************************
  localparam logic [15:0] mask_enable_4 = 16'h210e;
  localparam logic [15:0] mask_enable_5 = 16'h038e;
  localparam logic [15:0] mask_enable_6 = 16'h0010;
  localparam logic [15:0] mask_enable_7 = 16'h0020;
  localparam logic [15:0] mask_pri_full = 16'h7777;
  localparam logic [15:0] mask_pri_3    = 16'h0777;

  localparam int debug_port_irq_enable_bit  = 5;
  localparam int serial_unit_one_event_lsb  = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] rst_enable   = 16'h0000;
  localparam logic [15:0] rst_pri_full = 16'h4444;
  localparam logic [15:0] rst_pri_3    = 16'h0444;
  localparam logic [2:0]  pri_off      = 3'h0;

  // ****************************************************************
  // Bus constants
  // ****************************************************************
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [1:0] htrans_seq    = 2'h3;
  localparam logic [2:0] hsize_word    = 3'h2;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } iepr_req_t;

endpackage

// ### test/iepr_regs_checker.sv
// Port assertions for the enable and priority slice.
`timescale 1ns/10ps
module iepr_regs_checker #(
  parameter int num_src = 64
) (
  // Clock and reset
  input wire logic                 hclk,
  input wire logic                 hresetn,
  // Bus
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  input wire logic                 hresp,
  // Requests
  input wire logic [num_src-1:0]   src_req,
  input wire logic [num_src-1:0]   cpu_req,
  input wire logic [num_src*3-1:0] cpu_level
);
  logic rd_go;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  src_gate_a: assert property ((cpu_req & ~$past(src_req)) == '0)
    else $error("request passed with its source low");
  zero_level_a: assert property (cpu_req[1] |-> cpu_level[5:3] != 3'h0)
    else $error("request passed at level zero");
  upper_zero_a: assert property (rd_go |=> hrdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  pri_gap_a: assert property (rd_go && haddr[7:0] == 8'h1c |=> hrdata[15:11] == 5'h0)
    else $error("unused priority bits not zero");
  debug_bit_a: assert property (rd_go && haddr[7:0] == 8'h0c |=> (hrdata & 32'hffdf) == 32'h0)
    else $error("debug enable register shows stray bits");
  reset_quiet_a: assert property ($rose(hresetn) |-> cpu_req == '0 ##1 cpu_req == '0)
    else $error("request out of reset");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not okay");
endmodule
bind iepr_regs iepr_regs_checker #(.num_src(num_src)) i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hresp(hresp),
  .src_req(src_req),
  .cpu_req(cpu_req), .cpu_level(cpu_level));

// ### test/iepr_src_model.sv
// Peripheral request sources outside the slice.
`timescale 1ns/10ps
module iepr_src_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Commanded requests
  input  wire logic        route_ok,
  input  wire logic [63:0] want,
  output logic      [63:0] src_req
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      src_req <= '0;
    else
      src_req <= route_ok ? want : '0;
  end
endmodule

// ### test/iepr_regs_tb.sv
// Self-checking bench for the enable and priority slice.
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
module iepr_regs_tb;
  logic         hclk, hresetn, hsel, hwrite, hready, route_ok, irq;
  logic [1:0]   htrans;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [63:0]  want, src_req, cpu_req;
  logic [191:0] cpu_level;
  logic [15:0]  msk [8] = '{16'h210e, 16'h038e, 16'h0010, 16'h0020, 16'h7777, 16'h7777, 16'h7777, 16'h0777};
  int           fails, compares;
  iepr_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(iepr_pkg::hsize_word), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(), .src_req(src_req), .cpu_req(cpu_req), .cpu_level(cpu_level), .irq(irq));
  iepr_src_model i_src (.hclk(hclk), .hresetn(hresetn), .route_ok(route_ok), .want(want), .src_req(src_req));
  task wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task hold;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) begin
        fails++;
        wrap_up;
      end
    end while (hready !== 1'b1);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= iepr_pkg::htrans_nonseq;
    hwrite <= w;
    hold;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold;
    rd = hrdata;
  endtask
  task settle;
    repeat (6) @(posedge hclk);
  endtask
  task t_reset;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      `CHK(rd, i < 4 ? 32'h0 : (i < 7 ? 32'h4444 : 32'h0444))
    end
  endtask
  task t_mask;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'(i * 4), 32'hffff_ffff);
      bus(1'b0, 8'(i * 4), 32'h0);
      `CHK(rd, {16'h0, msk[i]})
    end
    bus(1'b1, 8'h18, 32'h0000_0500);
    bus(1'b0, 8'h18, 32'h0);
    settle;
    `CHK(rd, 32'h0000_0500)
    `CHK(cpu_level[32:30], 3'h5)
    bus(1'b1, 8'h28, 32'hffff_ffff);
    bus(1'b0, 8'h28, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task t_gate;
    route_ok <= 1'b1;
    want     <= 64'h2;
    bus(1'b1, 8'h00, 32'h0);
    settle;
    `CHK(cpu_req[1], 1'b0)
    bus(1'b1, 8'h00, 32'h2);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h10, 32'(c << 4));
      settle;
      `CHK(cpu_req[1], 1'(c != 0))
      `CHK(cpu_level[5:3], 3'(c))
    end
  endtask
  task t_irq;
    want <= 64'h0;
    bus(1'b1, 8'h24, 32'h1);
    bus(1'b1, 8'h20, 32'hf);
    settle;
    `CHK(irq, 1'b0)
    want <= 64'h2;
    settle;
    `CHK(irq, 1'b1)
    bus(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h1)
    bus(1'b1, 8'h24, 32'h0);
    settle;
    `CHK(irq, 1'b0)
    bus(1'b1, 8'h24, 32'h1);
    bus(1'b1, 8'h20, 32'h1);
    settle;
    `CHK(irq, 1'b0)
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, route_ok, htrans, haddr, hwdata, want} = '0;
    fails = 0;
    compares = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_mask;
    t_gate;
    t_irq;
    wrap_up;
  end
endmodule
